// *** rtl/mmd_indirect_access_portal.sv ***
// Purpose: Indirect register portal behind management registers 0xd and 0xe.
// Assumes: Register strobes come from the management logic on sys_clk.
// Notes: Reads answer one cycle after the strobe; write wins if both strobe.
//
// Function
// [R1] Decode 32 device addresses, 64K 16-bit registers each, via portal only.
// [R2] Mode bits 15:14: address, data, increment both, increment on writes.
// [R3] Device address from bits 4:0 applies to data-mode portal accesses only; address mode ignores it.
// [R4] Address mode: portal write stores address, portal read returns it.
// [R5] Data modes: portal accesses reach the selected indirect register.
// [R6] Mode 01 leaves stored address unchanged.
// [R7] Mode 10 increments address after each read and write.
// [R8] Mode 11 increments after writes only.
// [R9] Host sets address mode, address, data mode, then data.
// [R10] Mode 10 reads return consecutive registers from stored address.
// [R11] Device 1 register 0 bit 12 is read/write LPI enable, reset zero.
// [R12] Device 1 register 1 bit 8 latches high on LPI entry.
// [R13] Device 1 register 1 bit 3 shows live LPI state.
// [R14] Control and portal registers reset to zero.
// [R15] Status read clears entered flag unless entry still present.
// [R16] Unsupported indirect addresses read zero, writes ignored.
`timescale 1ns/1ns
`default_nettype none
`include "mmd_portal_params.svh"

module mmd_indirect_access_portal
    import mmd_portal_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [4:0] mgmtAddr,
    input wire logic mgmtWrite,
    input wire logic mgmtRead,
    input wire word_t mgmtWrData,
    output word_t mgmtRdData,
    output logic mgmtRdValid,
    output logic lpiEnable,
    input wire logic lpiActive
);
    word_t accessCtrl_ff;
    word_t regAddr_ff;
    word_t rdData_ff;
    logic rdValid_ff;
    word_t ctrlValue;
    word_t statusValue;
    op_mode_e mode;
    logic [4:0] devAddr;
    logic ctrlHit;
    logic portalHit;
    logic portalWr;
    logic portalRd;
    logic isData;
    logic selCtrl;
    logic selStatus;
    logic bump;
    word_t portalValue;

    // ========================================================================
    // Decode
    // [R2] Operation mode field.
    assign mode = op_mode_e'(accessCtrl_ff[`MMD_MODE_HI:`MMD_MODE_LO]);
    // [R3] Device field.
    assign devAddr = accessCtrl_ff[`MMD_DEV_HI:`MMD_DEV_LO];
    assign ctrlHit = (mgmtAddr == `MMD_OFS_ACCESS_CTRL);
    assign portalHit = (mgmtAddr == `MMD_OFS_PORTAL);
    assign portalWr = portalHit & mgmtWrite;
    // A read that meets a write in the same cycle is dropped, so the write wins.
    assign portalRd = portalHit & mgmtRead & ~mgmtWrite;
    assign isData = (mode != MODE_ADDRESS);
    // [R1] Full device and register match.
    assign selCtrl = (devAddr == `MMD_DEV_PMA) && (regAddr_ff == `MMD_REG_PMA_CONTROL_ONE);
    assign selStatus = (devAddr == `MMD_DEV_PMA) && (regAddr_ff == `MMD_REG_PMA_STATUS_ONE);

    // [R5] Indirect read data; [R16] unmapped reads zero.
    always_comb begin
        portalValue = 16'h0000;
        if (!isData) begin
            portalValue = regAddr_ff;
        end else if (selCtrl) begin
            portalValue = ctrlValue;
        end else if (selStatus) begin
            portalValue = statusValue;
        end
    end

    // [R6] [R7] [R8] Post-increment choice.
    always_comb begin
        unique case (mode)
            MODE_ADDRESS: bump = 1'b0;
            MODE_DATA_NOINC: bump = 1'b0;
            MODE_DATA_INC_RW: bump = portalWr | portalRd;
            MODE_DATA_INC_WR: bump = portalWr;
        endcase
    end

    // ========================================================================
    // Portal registers
    // [R14] Control reset to zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            accessCtrl_ff <= `MMD_ACCESS_CTRL_RESET;
        end else if (ctrlHit && mgmtWrite) begin
            accessCtrl_ff <= mgmtWrData;
        end
    end

    // [R4] Address store; [R10] stepping through consecutive registers.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regAddr_ff <= `MMD_PORTAL_RESET;
        end else if (portalWr && !isData) begin
            regAddr_ff <= mgmtWrData;
        end else if (bump) begin
            regAddr_ff <= regAddr_ff + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdData_ff <= 16'h0000;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= mgmtRead & ~mgmtWrite & (ctrlHit | portalHit);
            if (mgmtRead && !mgmtWrite && ctrlHit) begin
                rdData_ff <= accessCtrl_ff;
            end else if (portalRd) begin
                rdData_ff <= portalValue;
            end
        end
    end

    // ========================================================================
    // Device 1 registers
    // [R11] [R16] Writes reach only the supported control word.
    pma_lpi_regs u_pma (
        .sys_clk(sys_clk),
        .reset(reset),
        .ctrlWrite(portalWr && isData && selCtrl),
        .ctrlWrData(mgmtWrData),
        .statusRead(portalRd && isData && selStatus),
        .lpiActive(lpiActive),
        .ctrlValue(ctrlValue),
        .statusValue(statusValue)
    );

    assign mgmtRdData = rdData_ff;
    assign mgmtRdValid = rdValid_ff;
    assign lpiEnable = ctrlValue[`MMD_BIT_LPI_ENABLE];

    // ========================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Reset itself triggers this check, so the default disable must not apply here.
    a_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0) reset |=> // [R14]
        (accessCtrl_ff == 16'h0000) && (regAddr_ff == 16'h0000) && !lpiEnable)
        else $error("portal registers not zero after reset");
    a_addr_store: assert property (portalWr && mode == MODE_ADDRESS |=> // [R4]
        regAddr_ff == $past(mgmtWrData))
        else $error("address write not stored");
    a_addr_readback: assert property (portalRd && mode == MODE_ADDRESS |=> // [R4]
        mgmtRdValid && mgmtRdData == $past(regAddr_ff))
        else $error("address read mismatch");
    a_hold_noinc: assert property ((portalRd || portalWr) && mode == MODE_DATA_NOINC |=> // [R6]
        $stable(regAddr_ff))
        else $error("address moved in no-increment mode");
    a_inc_both: assert property ((portalRd || portalWr) && mode == MODE_DATA_INC_RW |=> // [R7]
        regAddr_ff == $past(regAddr_ff) + 16'h0001)
        else $error("address not incremented");
    a_inc_wr_only: assert property (portalHit && (mgmtRead || mgmtWrite) // [R8]
        && mode == MODE_DATA_INC_WR |=>
        regAddr_ff == $past(regAddr_ff) + {15'h0000, $past(mgmtWrite)})
        else $error("write-only increment wrong");
    a_unmapped_zero: assert property (portalRd && isData && devAddr != `MMD_DEV_PMA |=> // [R16]
        mgmtRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_enable_write: assert property (portalWr && isData && selCtrl |=> // [R11]
        lpiEnable == $past(mgmtWrData[`MMD_BIT_LPI_ENABLE]))
        else $error("enable bit not written");
    a_entered_latch: assert property (lpiActive ##1 !lpiActive && !portalRd |=> // [R12]
        statusValue[`MMD_BIT_LPI_ENTERED])
        else $error("entered flag not latched");
    a_entered_clear: assert property (portalRd && isData && selStatus && !lpiActive |=> // [R15]
        !statusValue[`MMD_BIT_LPI_ENTERED])
        else $error("entered flag not cleared by read");
    a_live_state: assert property (portalRd && isData && selStatus |=> // [R13]
        mgmtRdData[`MMD_BIT_LPI_ACTIVE] == $past(lpiActive))
        else $error("live state bit wrong");
    a_entered_read: assert property (portalRd && isData && selStatus |=> // [R12]
        mgmtRdData[`MMD_BIT_LPI_ENTERED] == $past(statusValue[`MMD_BIT_LPI_ENTERED]))
        else $error("entered flag not returned by status read");
    a_data_read: assert property (portalRd && isData && selCtrl |=> // [R5]
        mgmtRdData == $past(ctrlValue))
        else $error("control word read mismatch");
    a_unmapped_reg: assert property (portalRd && isData && !selCtrl && !selStatus |=> // [R16]
        mgmtRdData == 16'h0000)
        else $error("unsupported register read not zero");
    a_unmapped_write: assert property (portalWr && isData && !selCtrl |=> // [R16]
        $stable(ctrlValue))
        else $error("unsupported register write reached control word");
    a_enable_hold: assert property (!(portalWr && isData && selCtrl) |=> // [R11]
        $stable(lpiEnable))
        else $error("enable bit moved without a control write");
    a_ctrl_store: assert property (ctrlHit && mgmtWrite |=> // [R3]
        accessCtrl_ff == $past(mgmtWrData))
        else $error("access control write not stored");
    a_ctrl_readback: assert property (mgmtRead && !mgmtWrite && ctrlHit |=> // [R2]
        mgmtRdValid && mgmtRdData == $past(accessCtrl_ff))
        else $error("access control read mismatch");
    a_ctrl_no_step: assert property (ctrlHit && mgmtWrite |=> // [R7]
        $stable(regAddr_ff))
        else $error("address moved on control write");
    a_valid_source: assert property (mgmtRdValid |-> // [R1]
        $past(mgmtRead && !mgmtWrite && (ctrlHit || portalHit)))
        else $error("read answer without a portal read");

    // ========================================================================
    // Cover points
    c_data_write: cover property (portalWr && isData && selCtrl);
    c_status_read: cover property (portalRd && isData && selStatus);
    c_burst_read: cover property (portalRd && mode == MODE_DATA_INC_RW ##2 portalRd);
    c_inc_write: cover property (portalWr && mode == MODE_DATA_INC_WR);
    c_entry_read: cover property (lpiActive && portalRd && isData && selStatus);
endmodule // mmd_indirect_access_portal
`default_nettype wire

// *** rtl/mmd_portal_params.svh ***
// Purpose: Offsets, field positions, reset values for the indirect access portal.
// Assumes: Management registers are addressed by a 5-bit register number.
// Notes: Definitions only.
`ifndef MMD_PORTAL_PARAMS_SVH
`define MMD_PORTAL_PARAMS_SVH

// ============================================================================
// Management register numbers
`define MMD_OFS_ACCESS_CTRL 5'h0d
`define MMD_OFS_PORTAL 5'h0e

// ============================================================================
// Access control fields
`define MMD_MODE_HI 15
`define MMD_MODE_LO 14
`define MMD_DEV_HI 4
`define MMD_DEV_LO 0
`define MMD_ACCESS_CTRL_RESET 16'h0000
`define MMD_PORTAL_RESET 16'h0000

// ============================================================================
// Indirect device 1 map
`define MMD_DEV_PMA 5'h01
`define MMD_REG_PMA_CONTROL_ONE 16'h0000
`define MMD_REG_PMA_STATUS_ONE 16'h0001
`define MMD_PMA_CONTROL_RESET 16'h0000
`define MMD_BIT_LPI_ENABLE 12
`define MMD_BIT_LPI_ENTERED 8
`define MMD_BIT_LPI_ACTIVE 3

`endif

// *** rtl/mmd_portal_pkg.sv ***
// Purpose: Types shared by the indirect access portal.
// Assumes: Nothing beyond the parameter header.
// Notes: Mode codes follow the two-bit operation-mode field.
package mmd_portal_pkg;
    typedef enum logic [1:0] {
        MODE_ADDRESS = 2'h0,
        MODE_DATA_NOINC = 2'h1,
        MODE_DATA_INC_RW = 2'h2,
        MODE_DATA_INC_WR = 2'h3
    } op_mode_e;
    typedef logic [15:0] word_t;
endpackage

// *** rtl/pma_lpi_regs.sv ***
// Purpose: Control and status words of indirect device 1 for Low Power Idle.
// Assumes: lpiActive comes from logic on sys_clk.
// Notes: The entered flag is set-wins against its clear on read.
`timescale 1ns/1ns
`default_nettype none
`include "mmd_portal_params.svh"

module pma_lpi_regs
    import mmd_portal_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ctrlWrite,
    input wire word_t ctrlWrData,
    input wire logic statusRead,
    input wire logic lpiActive,
    output word_t ctrlValue,
    output word_t statusValue
);
    word_t ctrl_ff;
    logic entered_ff;

    // ========================================================================
    // Control word
    // [R11] Enable bit storage.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_ff <= `MMD_PMA_CONTROL_RESET;
        end else if (ctrlWrite) begin
            ctrl_ff <= ctrlWrData;
        end
    end

    // ========================================================================
    // Status word
    // [R12] Latch entry high.
    // [R15] Clear on read, set wins.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            entered_ff <= 1'b0;
        end else begin
            entered_ff <= lpiActive | (entered_ff & ~statusRead);
        end
    end

    assign ctrlValue = ctrl_ff;

    // [R13] Live state bit.
    always_comb begin
        statusValue = 16'h0000;
        statusValue[`MMD_BIT_LPI_ENTERED] = entered_ff;
        statusValue[`MMD_BIT_LPI_ACTIVE] = lpiActive;
    end
endmodule // pma_lpi_regs
`default_nettype wire

// *** bench/mgmt_host_model.sv ***
// Purpose: Station management host model that drives the register strobes.
// Assumes: One access per call, strobes one cycle wide.
// Notes: Idle address and data lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model
    import mmd_portal_pkg::*;
(
    input wire logic sys_clk,
    output logic [4:0] mgmtAddr,
    output logic mgmtWrite,
    output logic mgmtRead,
    output word_t mgmtWrData,
    input wire word_t mgmtRdData,
    input wire logic mgmtRdValid
);
    initial begin
        mgmtAddr = 5'h1f;
        mgmtWrite = 1'b0;
        mgmtRead = 1'b0;
        mgmtWrData = 16'hffff;
    end
    task automatic writeReg(input logic [4:0] a, input word_t d);
        @(posedge sys_clk);
        #10;
        mgmtAddr = a;
        mgmtWrData = d;
        mgmtWrite = 1'b1;
        @(posedge sys_clk);
        #10;
        mgmtWrite = 1'b0;
        mgmtAddr = ~a;
        mgmtWrData = ~d;
    endtask
    task automatic readReg(input logic [4:0] a, output word_t d, output logic v);
        @(posedge sys_clk);
        #10;
        mgmtAddr = a;
        mgmtRead = 1'b1;
        @(posedge sys_clk);
        #10;
        mgmtRead = 1'b0;
        mgmtAddr = ~a;
        v = mgmtRdValid;
        d = mgmtRdData;
    endtask
endmodule // mgmt_host_model
`default_nettype wire

// *** bench/mmd_indirect_access_portal_test.sv ***
// Purpose: Self-checking bench for the indirect access portal.
// Assumes: Host model issues every access.
// Notes: Expected words are built from the register map.
`timescale 1ns/1ns
`default_nettype none
module mmd_indirect_access_portal_test
    import mmd_portal_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic lpiActive = 1'b0;
    logic [4:0] mgmtAddr;
    logic mgmtWrite;
    logic mgmtRead;
    word_t mgmtWrData;
    word_t mgmtRdData;
    logic mgmtRdValid;
    logic lpiEnable;
    int mismatches = 0;
    int checks_done = 0;

    // ========================================================================
    // Clock, design and host
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    mmd_indirect_access_portal uut (.sys_clk(sys_clk), .reset(reset), .mgmtAddr(mgmtAddr),
        .mgmtWrite(mgmtWrite), .mgmtRead(mgmtRead), .mgmtWrData(mgmtWrData),
        .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid), .lpiEnable(lpiEnable),
        .lpiActive(lpiActive));
    mgmt_host_model host (.sys_clk(sys_clk), .mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite),
        .mgmtRead(mgmtRead), .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData),
        .mgmtRdValid(mgmtRdValid));

    // ========================================================================
    // Checks and closing
    task automatic expect_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, input word_t exp);
        word_t d;
        logic v;
        host.readReg(a, d, v);
        expect_bit(v, 1'b1);
        checks_done++;
        if (d !== exp) begin
            mismatches++;
            $display("wrong value at %0t: reg %h read %h expected %h", $time, a, d, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input word_t d);
        host.writeReg(a, d);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end

    // ========================================================================
    // Tests
    initial begin
        word_t d;
        logic v;
        repeat (10) @(posedge sys_clk);
        #10;
        reset = 1'b0;
        rd(5'h0d, 16'h0000);
        rd(5'h0e, 16'h0000);
        host.readReg(5'h05, d, v);
        expect_bit(v, 1'b0);
        $display("reset test done");
        wr(5'h0d, 16'h0001);
        wr(5'h0e, 16'h00a5);
        rd(5'h0e, 16'h00a5);
        wr(5'h0e, 16'h0000);
        rd(5'h0e, 16'h0000);
        wr(5'h0d, 16'h4001);
        wr(5'h0e, 16'h1000);
        @(posedge sys_clk);
        #10;
        expect_bit(lpiEnable, 1'b1);
        rd(5'h0d, 16'h4001);
        rd(5'h0e, 16'h1000);
        rd(5'h0e, 16'h1000);
        $display("write test done");
        wr(5'h0d, 16'h8001);
        rd(5'h0e, 16'h1000);
        rd(5'h0e, 16'h0000);
        rd(5'h0e, 16'h0000);
        wr(5'h0d, 16'h0001);
        rd(5'h0e, 16'h0003);
        wr(5'h0d, 16'hc001);
        rd(5'h0e, 16'h0000);
        wr(5'h0e, 16'hffff);
        wr(5'h0d, 16'h0001);
        rd(5'h0e, 16'h0004);
        $display("increment test done");
        wr(5'h0e, 16'h0001);
        wr(5'h0d, 16'h4001);
        lpiActive = 1'b1;
        rd(5'h0e, 16'h0108);
        lpiActive = 1'b0;
        rd(5'h0e, 16'h0100);
        rd(5'h0e, 16'h0000);
        wr(5'h0d, 16'h4002);
        rd(5'h0e, 16'h0000);
        $display("status test done");
        @(posedge sys_clk);
        #10;
        reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        #10;
        reset = 1'b0;
        expect_bit(lpiEnable, 1'b0);
        rd(5'h0d, 16'h0000);
        rd(5'h0e, 16'h0000);
        $display("mid-run reset test done");
        stop_test();
    end
endmodule // mmd_indirect_access_portal_test
`default_nettype wire
